// File: inc/cepn_pkg.sv
// constants and types for the card-edge parameter navigation block
// assumes a 100 MHz system clock and an AXI4-Lite register master
// Operation
// - selector zero means bank-selection state
// - toggle steps bank through zero to fifteen
// - four LEDs show bank in binary
// - positions one to F pick parameters
// - toggle steps selected parameter value
// - changing parameter position keeps bank
// - back to zero re-enters bank selection
// - immediate effect, commit within twenty seconds
// - bank zero position two toggles overlay
// - F plus down at power-up: boot loader
package cepn_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int DEB_TIME_US = 10;
    localparam int DEB_CYC = DEB_TIME_US * CLK_MHZ;
    localparam longint SAVE_TIME_S = 20;
    localparam longint SAVE_CYC_L = SAVE_TIME_S * CLK_MHZ * 1000000;
    localparam logic [31:0] SAVE_CYC = SAVE_CYC_L[31:0];
    // ------------------------------------------------------------
    // selector and banks
    // ------------------------------------------------------------
    localparam logic [3:0] POS_BANK = 4'h0;
    localparam logic [3:0] POS_BOOT = 4'hF;
    localparam logic [3:0] POS_OVERLAY = 4'h2;
    localparam logic [3:0] BANK_OVERLAY = 4'h0;
    localparam logic [3:0] BANK_MAX = 4'hF;
    localparam logic [3:0] BANK_MIN = 4'h0;
    localparam logic [7:0] PVAL_MAX = 8'hFF;
    localparam logic [7:0] PVAL_RST = 8'h00;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PVAL = 8'h08;
    localparam int CTRL_SAVE_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_BANK = 2'b01,
        ST_PARAM = 2'b10,
        ST_BOOT = 2'b11
    } cepn_state_t;
endpackage

// File: logic/cepn_nav.sv
// card-edge parameter navigation: selector, toggle, LEDs, parameter store
// assumes switch pins are asynchronous and a nonvolatile store acts on save_req
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module cepn_nav import cepn_pkg::*; #(
    parameter logic [31:0] SAVE_CYCLES = SAVE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] hex_sw,
    input wire logic nav_up,
    input wire logic nav_down,
    output logic [3:0] bank_led,
    output logic overlay_display_enable,
    output logic boot_mode,
    output logic save_req,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // synchronisers and debounce
    // ------------------------------------------------------------
    logic [5:0] meta_reg, sync_reg, cand_reg, deb_reg, deb_prev_reg;
    logic [15:0] deb_cnt_reg;
    wire deb_stable = (deb_cnt_reg == 16'(DEB_CYC));
    // two flops before anything looks at the pins
    always_ff @(posedge clk) begin
        meta_reg <= {nav_down, nav_up, hex_sw};
        sync_reg <= meta_reg;
    end
    // one shared timer: any bounce on any input restarts it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cand_reg <= 6'h00;
            deb_cnt_reg <= 16'h0000;
            deb_reg <= 6'h00;
            deb_prev_reg <= 6'h00;
        end else begin
            cand_reg <= sync_reg;
            deb_prev_reg <= deb_reg;
            if (sync_reg != cand_reg) begin
                deb_cnt_reg <= 16'h0000;
            end else if (!deb_stable) begin
                deb_cnt_reg <= deb_cnt_reg + 16'h0001;
            end
            if (deb_stable) begin
                deb_reg <= cand_reg;
            end
        end
    end
    wire [3:0] pos = deb_reg[3:0];
    wire up_hit = deb_reg[4] & ~deb_prev_reg[4] & ~deb_reg[5];
    wire dn_hit = deb_reg[5] & ~deb_prev_reg[5] & ~deb_reg[4];
    // ------------------------------------------------------------
    // navigation state
    // ------------------------------------------------------------
    cepn_state_t state_reg, state_next;
    logic [3:0] bank_reg;
    logic init_seen_reg;
    // first settled sample after reset decides boot versus normal
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_INIT: begin
                if (init_seen_reg && deb_reg[3:0] == POS_BOOT && deb_reg[5]) begin
                    state_next = ST_BOOT;
                end else if (init_seen_reg) begin
                    state_next = (pos == POS_BANK) ? ST_BANK : ST_PARAM;
                end
            end
            ST_BANK: begin
                if (pos != POS_BANK) state_next = ST_PARAM;
            end
            ST_PARAM: begin
                if (pos == POS_BANK) state_next = ST_BANK;
            end
            default: state_next = ST_BOOT; // boot loader holds until reset
        endcase
    end
    // bank only moves in bank-selection state and saturates at the ends
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_INIT;
            bank_reg <= BANK_MIN;
            init_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            init_seen_reg <= init_seen_reg | deb_stable;
            if (state_reg == ST_BANK && pos == POS_BANK) begin
                if (up_hit && bank_reg != BANK_MAX) bank_reg <= bank_reg + 4'h1;
                else if (dn_hit && bank_reg != BANK_MIN) bank_reg <= bank_reg - 4'h1;
            end
        end
    end
    assign bank_led = bank_reg; // bit 0 is the top LED
    assign boot_mode = (state_reg == ST_BOOT);
    // ------------------------------------------------------------
    // parameter store, one byte per bank and position
    // ------------------------------------------------------------
    logic [7:0] param_mem_reg [0:255];
    wire [7:0] sel_idx = {bank_reg, pos}; // bank stays, position picks
    wire [7:0] sel_val = param_mem_reg[sel_idx];
    wire is_overlay = (bank_reg == BANK_OVERLAY) && (pos == POS_OVERLAY);
    wire adj_ok = (state_reg == ST_PARAM) && (pos != POS_BANK);
    wire change = adj_ok && (up_hit || dn_hit);
    wire [7:0] step_val = is_overlay ? {7'h00, ~sel_val[0]} :
        (up_hit ? ((sel_val == PVAL_MAX) ? sel_val : sel_val + 8'h01) :
        ((sel_val == PVAL_RST) ? sel_val : sel_val - 8'h01));
    genvar gi;
    generate
        for (gi = 0; gi < 256; gi++) begin : g_entry
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    param_mem_reg[gi] <= PVAL_RST;
                end else if (change && sel_idx == 8'(gi)) begin
                    param_mem_reg[gi] <= step_val; // takes effect at once
                end
            end
        end
    endgenerate
    assign overlay_display_enable = param_mem_reg[{BANK_OVERLAY, POS_OVERLAY}][0];
    // ------------------------------------------------------------
    // commit timer: counted from the first unsaved change, so the
    // latest change is never more than SAVE_CYCLES from storage
    // ------------------------------------------------------------
    logic dirty_reg, save_req_reg, sw_save;
    logic [31:0] save_cnt_reg;
    wire save_due = dirty_reg && (save_cnt_reg >= SAVE_CYCLES - 32'h1 || sw_save);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dirty_reg <= 1'b0;
            save_cnt_reg <= 32'h0;
            save_req_reg <= 1'b0;
        end else begin
            save_req_reg <= save_due;
            if (change) dirty_reg <= 1'b1; // a change in the save cycle stays dirty
            else if (save_due) dirty_reg <= 1'b0;
            if (save_due || !dirty_reg) save_cnt_reg <= 32'h0;
            else save_cnt_reg <= save_cnt_reg + 32'h1;
        end
    end
    assign save_req = save_req_reg;
    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg;
    logic [1:0] bresp_reg, rresp_reg;
    assign s_axi_awready = !aw_have_reg && !bvalid_reg;
    assign s_axi_wready = !w_have_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    wire wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
    wire wr_ctrl = wr_go && awaddr_reg == ADDR_CTRL;
    assign sw_save = wr_ctrl && wdata_reg[CTRL_SAVE_BIT]; // forced commit
    wire rd_go = s_axi_arvalid && !rvalid_reg;
    wire [31:0] status_word = {19'h0, dirty_reg, pos, bank_reg, 2'h0, state_reg};
    wire rd_ok = s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_STATUS ||
        s_axi_araddr == ADDR_PVAL;
    wire [31:0] rd_word = (s_axi_araddr == ADDR_STATUS) ? status_word :
        (s_axi_araddr == ADDR_PVAL) ? {24'h0, sel_val} : 32'h0;
    // address and data may arrive in either order; answer follows both
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            rdata_reg <= 32'h0;
            bresp_reg <= RESP_OKAY;
            rresp_reg <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                wdata_reg <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0;
            end
            if (wr_go) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (awaddr_reg == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_go) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_word;
                rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // the state register trails the debounced selector by one edge, so check the step after
    a_bank_zero_state: assert property (pos == POS_BANK && (state_reg == ST_BANK ||
        state_reg == ST_PARAM) |=> state_reg == ST_BANK)
        else $error("selector zero left bank selection");
    a_bank_step_up: assert property (state_reg == ST_BANK && pos == POS_BANK && up_hit
        && bank_reg != BANK_MAX |=> bank_reg == $past(bank_reg) + 4'h1)
        else $error("bank did not step up");
    a_led_mirror: assert property (bank_led == bank_reg)
        else $error("leds differ from bank");
    a_param_bank_hold: assert property (state_reg == ST_PARAM |=> $stable(bank_reg))
        else $error("bank moved during parameter adjust");
    a_param_step: assert property (change && up_hit && !is_overlay && sel_val != PVAL_MAX
        |=> param_mem_reg[$past(sel_idx)] == $past(sel_val) + 8'h01)
        else $error("parameter did not increment");
    a_zero_reenter: assert property (state_reg == ST_PARAM && pos == POS_BANK
        |=> state_reg == ST_BANK)
        else $error("no return to bank selection");
    a_save_bound: assert property (dirty_reg |-> save_cnt_reg < SAVE_CYCLES)
        else $error("commit overdue");
    a_overlay_flip: assert property (change && is_overlay
        |=> overlay_display_enable != $past(overlay_display_enable))
        else $error("overlay did not toggle");
    a_boot_hold: assert property (boot_mode |=> boot_mode ##1 bank_led == $past(bank_led))
        else $error("boot mode left");
    a_bank_bound: assert property (bank_reg == BANK_MAX && up_hit |=> bank_reg == BANK_MAX)
        else $error("bank wrapped");
    c_bank_step: cover property (state_reg == ST_BANK && up_hit ##1 bank_reg != BANK_MIN);
    c_param_change: cover property (change);
    c_save: cover property (save_req);
    c_boot: cover property (boot_mode);
endmodule

// File: tb/cepn_operator.sv
// operator model: rotary selector and up/down toggle at the card edge
// assumes the bench calls its tasks from a process tied to clk
`timescale 1ns/1ns
module cepn_operator (
    input wire logic clk,
    output logic [3:0] hex_sw,
    output logic nav_up,
    output logic nav_down
);
    // -------------------------------------------------------------
    // switch handling
    // -------------------------------------------------------------
    // idle at power-up: selector at zero, toggle centred
    initial begin
        hex_sw = 4'h0;
        nav_up = 1'b0;
        nav_down = 1'b0;
    end
    // lines move just after an edge, then stay long enough to be taken
    task automatic set_lines(input logic [3:0] sel, input logic up, input logic dn);
        @(posedge clk);
        hex_sw <= sel;
        nav_up <= up;
        nav_down <= dn;
        repeat (1020) @(posedge clk);
    endtask
    // a real toggle chatters before it settles, so it bounces first
    task automatic press(input logic up);
        int i;
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            nav_up <= up ? ~nav_up : 1'b0;
            nav_down <= up ? 1'b0 : ~nav_down;
        end
        set_lines(hex_sw, up, ~up);
        set_lines(hex_sw, 1'b0, 1'b0);
    endtask
endmodule

// File: tb/tb.sv
// bench for the navigation block: operator model plus AXI4-Lite master
// assumes a shortened save delay: shorter than one press, longer than the rest of a press after its toggle
`timescale 1ns/1ns
module tb import cepn_pkg::*;;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, nav_up, nav_down;
    logic overlay, boot_mode, save_req;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb, hex_sw, bank_led;
    logic [1:0] bresp, rresp, rs;
    int miscompares, cmp_count, saves, s0, i;
    cepn_operator op (.clk(clk), .hex_sw(hex_sw), .nav_up(nav_up), .nav_down(nav_down));
    cepn_nav #(.SAVE_CYCLES(32'h000005DC)) dut (.clk(clk), .rst_n(rst_n), .hex_sw(hex_sw),
        .nav_up(nav_up), .nav_down(nav_down), .bank_led(bank_led),
        .overlay_display_enable(overlay), .boot_mode(boot_mode), .save_req(save_req),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task conclude;
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // both channels offered together; each released once taken
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            miscompares++;
            conclude();
        end
    endtask
    task axr(input logic [7:0] a);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rd = rdata;
                rs = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            miscompares++;
            conclude();
        end
    endtask
    // reset, then wait out the power-up switch decision
    task do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (1100) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // commit pulses are counted so each change can be matched to one save
    always @(posedge clk) if (save_req === 1'b1) saves <= saves + 1;
    // hang guard well above the longest expected run
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        conclude();
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        {miscompares, cmp_count, saves} = 0;
        do_reset();
        check("bank_led", {28'h0, bank_led}, 32'h0);
        axr(ADDR_STATUS);
        check("state", {30'h0, rd[1:0]}, 32'h1);
        op.press(1'b0);
        check("bank_led", {28'h0, bank_led}, 32'h0);
        for (i = 1; i <= 16; i++) begin
            op.press(1'b1);
            check("bank_led", {28'h0, bank_led}, (i > 15) ? 15 : i);
        end
        op.press(1'b0);
        check("bank_led", {28'h0, bank_led}, 32'hE);
        do_reset();
        op.set_lines(POS_OVERLAY, 1'b0, 1'b0);
        axr(ADDR_STATUS);
        check("state", {30'h0, rd[1:0]}, 32'h2);
        s0 = saves;
        op.press(1'b1);
        check("overlay", {31'h0, overlay}, 32'h1);
        check("saves", saves, s0);
        // lane 0 off means the commit bit reads as zero: no forced commit
        axw(ADDR_CTRL, 32'hFFFFFFFF, 4'hE);
        repeat (2) @(posedge clk);
        check("saves", saves, s0);
        axw(ADDR_CTRL, 32'h00000001, 4'hF);
        repeat (2) @(posedge clk);
        check("saves", saves, s0 + 1);
        axr(ADDR_PVAL);
        check("pval", rd, 32'h1);
        check("rresp", {30'h0, rs}, {30'h0, RESP_OKAY});
        op.set_lines(4'h3, 1'b0, 1'b0);
        op.press(1'b0);
        op.press(1'b1);
        op.press(1'b1);
        axr(ADDR_PVAL);
        check("pval", rd, 32'h2);
        op.set_lines(POS_OVERLAY, 1'b0, 1'b0);
        axr(ADDR_PVAL);
        check("pval", rd, 32'h1);
        axr(ADDR_STATUS);
        check("status", {19'h0, rd[12], 8'h0, rd[7:4]}, 32'h0);
        check("saves", saves, s0 + 4);
        op.set_lines(POS_BANK, 1'b0, 1'b0);
        op.press(1'b1);
        check("bank_led", {28'h0, bank_led}, 32'h1);
        op.set_lines(4'h3, 1'b0, 1'b0);
        axr(ADDR_PVAL);
        check("pval", rd, 32'h0);
        axw(ADDR_CTRL, 32'h00000001, 4'hF);
        check("bresp", {30'h0, rs}, {30'h0, RESP_OKAY});
        axw(ADDR_STATUS, 32'h00000001, 4'hF);
        check("bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        axw(8'hFC, 32'h00000000, 4'h1);
        check("bresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        axr(8'h0C);
        check("rdata", rd, 32'h0);
        check("rresp", {30'h0, rs}, {30'h0, RESP_SLVERR});
        op.set_lines(POS_BOOT, 1'b0, 1'b1);
        do_reset();
        check("boot_mode", {31'h0, boot_mode}, 32'h1);
        op.set_lines(POS_BANK, 1'b0, 1'b0);
        op.press(1'b1);
        check("bank_led", {28'h0, bank_led}, 32'h0);
        conclude();
    end
endmodule
